// file: hw/pgc_pkg.sv
package pgc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_REG = 4;
    localparam int RATE_W = 5;

    // Register addresses
    localparam logic [7:0] ADDR_PG_SRC = 8'h28;
    localparam logic [7:0] ADDR_PG_CTRL = 8'h29;
    localparam logic [7:0] ADDR_PG_FAULT = 8'h2a;
    localparam logic [7:0] ADDR_CLK_CTRL = 8'h2b;

    // Reset values
    localparam logic [7:0] RST_PG_SRC = 8'h00;
    localparam logic [7:0] RST_PG_CTRL = 8'h00;
    localparam logic [7:0] RST_CLK_CTRL = 8'h00;

    // Writable-bit masks and fault read mask, reserved bits held at zero
    localparam logic [7:0] MASK_PG_CTRL = 8'hf7;
    localparam logic [7:0] MASK_PG_FAULT = 8'h0f;
    localparam logic [7:0] MASK_CLK_CTRL = 8'hdf;

    // Power-good control fields
    localparam int CTRL_HALF = 7;
    localparam int CTRL_MERGE = 6;
    localparam int CTRL_DEB = 5;
    localparam int CTRL_LATCH = 4;
    localparam int CTRL_WIN = 2;
    localparam int CTRL_OD = 1;
    localparam int CTRL_POL = 0;

    // Clock control fields
    localparam int CLK_MODE_HI = 7;
    localparam int CLK_MODE_LO = 6;
    localparam int CLK_RATE_HI = 4;
    localparam logic [4:0] RATE_MAX = 5'h17;

    // Source selector codes
    localparam logic [1:0] SRC_MASKED = 2'h0;
    localparam logic [1:0] SRC_VOLT = 2'h1;
    localparam logic [1:0] SRC_VOLT_ILIM = 2'h3;

    typedef enum logic [1:0] {
        PLL_OFF,
        PLL_ALWAYS,
        PLL_ACTIVE_ONLY,
        PLL_RESERVED
    } pgc_pll_mode_type;

    // Timing
    localparam int CLK_MHZ = 50;
    localparam int STEP_FULL_NS = 500000;
    localparam int STEP_FULL_DBL_NS = 1000000;
    localparam int STEP_HALF_NS = 320000;
    localparam int STEP_HALF_DBL_NS = 640000;
    localparam int DEB_SHORT_NS = 4000;
    localparam int DEB_LONG_NS = 11000000;
    localparam int EXT_MIN_PERIODS = 2;

    localparam int STEP_FULL_CYC = STEP_FULL_NS * CLK_MHZ / 1000;
    localparam int STEP_FULL_DBL_CYC = STEP_FULL_DBL_NS * CLK_MHZ / 1000;
    localparam int STEP_HALF_CYC = STEP_HALF_NS * CLK_MHZ / 1000;
    localparam int STEP_HALF_DBL_CYC = STEP_HALF_DBL_NS * CLK_MHZ / 1000;
    localparam int DEB_SHORT_CYC = (DEB_SHORT_NS * CLK_MHZ + 999) / 1000;
    localparam int DEB_LONG_CYC = (DEB_LONG_NS * CLK_MHZ + 999) / 1000;
endpackage

// file: hw/pgc_clk_presence.sv
`timescale 1ns/1ps
module pgc_clk_presence #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ext_clock_in,
    input wire logic [pgc_pkg::RATE_W-1:0] rate_code,
    output logic present,
    output logic change
);
    import pgc_pkg::*;

    if (CNT_W < 7 || CNT_W > 16) begin : g_chk
        $error("pgc_clk_presence: CNT_W out of range");
    end

    // Allowed gap is a few expected periods of the programmed rate
    function automatic logic [CNT_W-1:0] timeout_f(input logic [RATE_W-1:0] code);
        logic [RATE_W-1:0] c;
        c = (code > RATE_MAX) ? RATE_MAX : code;
        timeout_f = CNT_W'(EXT_MIN_PERIODS * CLK_MHZ / (int'(c) + 1) + 2);
    endfunction

    logic s1_q, s2_q, s3_q;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic present_q, present_d;
    logic change_q;
    wire edge_w = s2_q ^ s3_q;
    wire [CNT_W-1:0] limit_w = timeout_f(rate_code);

    assign cnt_d = edge_w ? '0 : (cnt_q >= limit_w) ? cnt_q : cnt_q + 1'b1;
    assign present_d = edge_w ? 1'b1 : (cnt_q >= limit_w) ? 1'b0 : present_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            cnt_q <= '0;
            present_q <= 1'b0;
            change_q <= 1'b0;
        end else begin
            s1_q <= ext_clock_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            cnt_q <= cnt_d;
            present_q <= present_d;
            change_q <= present_d != present_q;
        end
    end

    assign present = present_q;
    assign change = change_q;
endmodule

// file: hw/pgc_ctrl.sv
// How it works
// - Delay step 0.5/1 ms, halved 0.32/0.64 ms
// - Merge bit ORs regulator-0 fault into irq
// - Debounce only rising valid: 4 us / 11 ms
// - Latched mode follows fault flags, else live
// - Window bit adds overvoltage to undervoltage check
// - Drive type: push-pull or open-drain
// - Polarity bit inverts power-good level
// - Per-regulator fault flag, reset zero
// - Read clears flag only if output valid
// - Mode 0 or reserved: PLL off, internal
// - Mode 1: PLL in standby or active, external when present
// - Mode 2: PLL only while active
// - Modes 1/2 pulse on external clock change
// - Rate code n means n+1 MHz, codes above 23 as 24 MHz
// - Selector: masked, voltage, voltage and current
`timescale 1ns/1ps
module pgc_ctrl #(
    parameter int STEP_FULL = pgc_pkg::STEP_FULL_CYC,
    parameter int STEP_FULL_DBL = pgc_pkg::STEP_FULL_DBL_CYC,
    parameter int STEP_HALF = pgc_pkg::STEP_HALF_CYC,
    parameter int STEP_HALF_DBL = pgc_pkg::STEP_HALF_DBL_CYC,
    parameter int DEB_LONG = pgc_pkg::DEB_LONG_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [pgc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pgc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [pgc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [pgc_pkg::NUM_REG-1:0] reg_uv_ok,
    input wire logic [pgc_pkg::NUM_REG-1:0] reg_ov_ok,
    input wire logic [pgc_pkg::NUM_REG-1:0] reg_ilim,
    input wire logic int_request,
    input wire logic dev_standby,
    input wire logic dev_active,
    input wire logic double_delay,
    input wire logic ext_clock_in,
    output logic power_good_out,
    output logic power_good_oe,
    output logic irq_out_n,
    output logic pll_enable,
    output logic use_ext_clock,
    output logic ext_clk_irq,
    output logic delay_step_tick
);
    import pgc_pkg::*;

    localparam int CW = 20;

    if (STEP_FULL < 1 || STEP_FULL_DBL < 1 || STEP_HALF < 1 || STEP_HALF_DBL < 1
        || DEB_LONG <= DEB_SHORT_CYC || DEB_LONG >= 2 ** CW
        || STEP_FULL_DBL >= 2 ** CW || STEP_HALF_DBL >= 2 ** CW) begin : g_chk
        $error("pgc_ctrl: timing parameter out of range");
    end

    function automatic logic src_ok_f(input logic [1:0] sel, input logic uv, input logic ov,
                                      input logic ilim, input logic win);
        logic volt;
        volt = uv & (ov | ~win);
        case (sel)
            SRC_VOLT: src_ok_f = volt;
            SRC_VOLT_ILIM: src_ok_f = volt & ~ilim;
            default: src_ok_f = 1'b1;
        endcase
    endfunction

    // Registers
    logic [7:0] pg_src_q, pg_ctrl_q, clk_ctrl_q;
    logic [NUM_REG-1:0] fault_q, fault_d;
    logic [7:0] rdata_q, rdata_d;

    // Analogue status synchronisers
    logic [3*NUM_REG-1:0] stat_s1_q, stat_s2_q;
    logic [NUM_REG-1:0] ok_prev_q;

    // Debounce and step timers
    logic [CW-1:0] deb_cnt_q, deb_cnt_d;
    logic pg_valid_q, pg_valid_d;
    logic [CW-1:0] step_cnt_q, step_cnt_d;

    // Output flops
    logic pg_out_q, pg_oe_q, irq_n_q, pll_en_q, use_ext_q, ext_irq_q, tick_q;

    wire [NUM_REG-1:0] uv_w = stat_s2_q[NUM_REG-1:0];
    wire [NUM_REG-1:0] ov_w = stat_s2_q[2*NUM_REG-1:NUM_REG];
    wire [NUM_REG-1:0] ilim_w = stat_s2_q[3*NUM_REG-1:2*NUM_REG];

    wire [NUM_REG-1:0] ok_w;
    wire [NUM_REG-1:0] unmasked_w;
    for (genvar i = 0; i < NUM_REG; i++) begin : g_reg
        assign ok_w[i] = src_ok_f(pg_src_q[2*i+1:2*i], uv_w[i], ov_w[i], ilim_w[i],
                                  pg_ctrl_q[CTRL_WIN]);
        assign unmasked_w[i] = (pg_src_q[2*i+1:2*i] == SRC_VOLT)
                               || (pg_src_q[2*i+1:2*i] == SRC_VOLT_ILIM);
    end

    // Register access decode
    wire wr_src_w = reg_we && (reg_addr == ADDR_PG_SRC);
    wire wr_ctrl_w = reg_we && (reg_addr == ADDR_PG_CTRL);
    wire wr_clk_w = reg_we && (reg_addr == ADDR_CLK_CTRL);
    wire rd_fault_w = reg_re && (reg_addr == ADDR_PG_FAULT);

    // Fault capture, set beats read-clear
    wire [NUM_REG-1:0] drop_w = ok_prev_q & ~ok_w & unmasked_w;
    wire [NUM_REG-1:0] clr_w = rd_fault_w ? (fault_q & ok_w) : '0;
    assign fault_d = (fault_q & ~clr_w) | drop_w;

    assign rdata_d = !reg_re ? rdata_q
                   : (reg_addr == ADDR_PG_SRC) ? pg_src_q
                   : (reg_addr == ADDR_PG_CTRL) ? pg_ctrl_q
                   : (reg_addr == ADDR_PG_FAULT) ? (8'(fault_q) & MASK_PG_FAULT)
                   : (reg_addr == ADDR_CLK_CTRL) ? clk_ctrl_q
                   : 8'h00;

    // Power-good qualification and debounce
    wire live_valid_w = &ok_w;
    wire raw_valid_w = pg_ctrl_q[CTRL_LATCH] ? ~|fault_q : live_valid_w;
    wire [CW-1:0] deb_target_w = pg_ctrl_q[CTRL_DEB] ? CW'(DEB_LONG) : CW'(DEB_SHORT_CYC);
    assign pg_valid_d = !raw_valid_w ? 1'b0
                      : (pg_valid_q || deb_cnt_q >= deb_target_w - 1'b1);
    assign deb_cnt_d = (!raw_valid_w || pg_valid_q) ? '0 : deb_cnt_q + 1'b1;

    wire pg_level_w = pg_valid_q ^ pg_ctrl_q[CTRL_POL];
    wire pg_out_d = pg_ctrl_q[CTRL_OD] ? 1'b0 : pg_level_w;
    wire pg_oe_d = pg_ctrl_q[CTRL_OD] ? ~pg_level_w : 1'b1;
    wire irq_n_d = ~(int_request | (pg_ctrl_q[CTRL_MERGE] & ~ok_w[0]));

    // Start-up and shutdown step tick
    wire [CW-1:0] step_len_w = pg_ctrl_q[CTRL_HALF]
                             ? (double_delay ? CW'(STEP_HALF_DBL) : CW'(STEP_HALF))
                             : (double_delay ? CW'(STEP_FULL_DBL) : CW'(STEP_FULL));
    wire step_wrap_w = step_cnt_q >= step_len_w - 1'b1;
    assign step_cnt_d = step_wrap_w ? '0 : step_cnt_q + 1'b1;

    // Clock source selection
    logic ext_present, ext_change;
    pgc_clk_presence #(
        .CNT_W(8)
    ) u_presence (
        .clk(clk),
        .rst_n(rst_n),
        .ext_clock_in(ext_clock_in),
        .rate_code(clk_ctrl_q[CLK_RATE_HI:0]),
        .present(ext_present),
        .change(ext_change)
    );

    pgc_pll_mode_type mode_w;
    assign mode_w = pgc_pll_mode_type'(clk_ctrl_q[CLK_MODE_HI:CLK_MODE_LO]);
    wire mode_auto_w = (mode_w == PLL_ALWAYS) || (mode_w == PLL_ACTIVE_ONLY);
    wire pll_en_d = (mode_w == PLL_ALWAYS) ? (dev_standby | dev_active)
                  : (mode_w == PLL_ACTIVE_ONLY) ? dev_active
                  : 1'b0;
    wire use_ext_d = pll_en_d && mode_auto_w && ext_present;
    wire ext_irq_d = mode_auto_w && ext_change;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pg_src_q <= RST_PG_SRC;
            pg_ctrl_q <= RST_PG_CTRL;
            clk_ctrl_q <= RST_CLK_CTRL;
            fault_q <= '0;
            rdata_q <= 8'h00;
            stat_s1_q <= '0;
            stat_s2_q <= '0;
            ok_prev_q <= '0;
        end else begin
            if (wr_src_w) begin
                pg_src_q <= reg_wdata;
            end
            if (wr_ctrl_w) begin
                pg_ctrl_q <= reg_wdata & MASK_PG_CTRL;
            end
            if (wr_clk_w) begin
                clk_ctrl_q <= reg_wdata & MASK_CLK_CTRL;
            end
            fault_q <= fault_d;
            rdata_q <= rdata_d;
            stat_s1_q <= {reg_ilim, reg_ov_ok, reg_uv_ok};
            stat_s2_q <= stat_s1_q;
            ok_prev_q <= ok_w;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            deb_cnt_q <= '0;
            pg_valid_q <= 1'b0;
            step_cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            deb_cnt_q <= deb_cnt_d;
            pg_valid_q <= pg_valid_d;
            step_cnt_q <= step_cnt_d;
            tick_q <= step_wrap_w;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pg_out_q <= 1'b0;
            pg_oe_q <= 1'b1;
            irq_n_q <= 1'b1;
            pll_en_q <= 1'b0;
            use_ext_q <= 1'b0;
            ext_irq_q <= 1'b0;
        end else begin
            pg_out_q <= pg_out_d;
            pg_oe_q <= pg_oe_d;
            irq_n_q <= irq_n_d;
            pll_en_q <= pll_en_d;
            use_ext_q <= use_ext_d;
            ext_irq_q <= ext_irq_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign power_good_out = pg_out_q;
    assign power_good_oe = pg_oe_q;
    assign irq_out_n = irq_n_q;
    assign pll_enable = pll_en_q;
    assign use_ext_clock = use_ext_q;
    assign ext_clk_irq = ext_irq_q;
    assign delay_step_tick = tick_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_fault_set_drop: assert property (
        |drop_w |=> ((fault_q & $past(drop_w)) == $past(drop_w)))
        else $error("fault flag not set on drop");
    a_fault_hold_bad: assert property (
        rd_fault_w |=> ((fault_q & $past(fault_q & ~ok_w)) == $past(fault_q & ~ok_w)))
        else $error("fault flag cleared while output invalid");
    a_fault_clear_ok: assert property (
        rd_fault_w |=> ((fault_q & $past(fault_q & ok_w)) == '0))
        else $error("fault flag kept after read with valid output");
    a_fault_masked: assert property (
        ((fault_q & ~$past(fault_q)) & ~$past(unmasked_w)) == '0)
        else $error("fault flag set for masked regulator");
    a_deb_fall_fast: assert property (
        !raw_valid_w |=> !pg_valid_q)
        else $error("power-good not dropped at once");
    a_deb_rise_slow: assert property (
        (raw_valid_w && !pg_valid_q && deb_cnt_q == '0) |=> !pg_valid_q [*8])
        else $error("power-good valid before debounce");
    a_pg_push_pull: assert property (
        (!pg_ctrl_q[CTRL_OD] && $stable(pg_ctrl_q)) |=>
            (power_good_oe && power_good_out == $past(pg_valid_q ^ pg_ctrl_q[CTRL_POL])))
        else $error("push-pull level wrong");
    a_pg_open_drain: assert property (
        pg_ctrl_q[CTRL_OD] |=>
            (!power_good_out && power_good_oe == !$past(pg_valid_q ^ pg_ctrl_q[CTRL_POL])))
        else $error("open-drain drive wrong");
    a_irq_merge: assert property (
        (!int_request && !pg_ctrl_q[CTRL_MERGE]) |=> irq_out_n)
        else $error("irq low without cause");
    a_pll_off_mode: assert property (
        (mode_w == PLL_OFF || mode_w == PLL_RESERVED) |=> (!pll_enable && !use_ext_clock))
        else $error("pll active in off mode");
    a_pll_active_only: assert property (
        (mode_w == PLL_ACTIVE_ONLY && !dev_active) |=> !pll_enable)
        else $error("pll enabled outside active state");
    a_ext_change_irq: assert property (
        (ext_change && mode_auto_w) |=> ext_clk_irq ##1 !ext_clk_irq [*2])
        else $error("external clock change not signalled once");
    a_rsvd_zero: assert property (
        rd_fault_w |=> (reg_rdata[7:4] == 4'h0))
        else $error("reserved fault bits not zero");
    a_step_tick: assert property (
        delay_step_tick |=> !delay_step_tick)
        else $error("step tick longer than one cycle");
    a_latched_hold: assert property (
        (pg_ctrl_q[CTRL_LATCH] && |fault_q) |=> !pg_valid_q)
        else $error("power-good valid while fault flag set");
    a_window_ov: assert property (
        (unmasked_w[0] && uv_w[0] && !ilim_w[0]) |->
            (ok_w[0] == (ov_w[0] || !pg_ctrl_q[CTRL_WIN])))
        else $error("window setting not applied to overvoltage");
    a_ilim_drop: assert property (
        (pg_src_q[1:0] == SRC_VOLT_ILIM && ilim_w[0]) |-> !ok_w[0])
        else $error("current limit ignored by selector");
    a_masked_ok: assert property (
        (pg_src_q[1:0] == SRC_MASKED) |-> ok_w[0])
        else $error("masked regulator affects power-good");
    a_irq_pass: assert property (
        int_request |=> !irq_out_n)
        else $error("interrupt condition not on irq pin");
    a_irq_pg_low: assert property (
        (pg_ctrl_q[CTRL_MERGE] && !ok_w[0]) |=> !irq_out_n)
        else $error("merged power-good not on irq pin");
    a_pll_always: assert property (
        (mode_w == PLL_ALWAYS && (dev_standby || dev_active)) |=> pll_enable)
        else $error("pll not enabled in standby or active");
    a_ext_select: assert property (
        (mode_auto_w && pll_en_d && ext_present) |=> use_ext_clock)
        else $error("external clock present but not selected");

    c_fault_set: cover property (|drop_w);
    c_fault_read_clear: cover property (rd_fault_w && |(fault_q & ok_w));
    c_pg_valid_rise: cover property ($rose(pg_valid_q));
    c_ext_irq: cover property (ext_clk_irq);
    c_latched_drop: cover property (pg_ctrl_q[CTRL_LATCH] && |fault_q);
endmodule

// file: testbench/pgc_far_model.sv
`timescale 1ns/1ps
module pgc_far_model (
    input wire logic ext_on,
    input wire logic power_good_out,
    input wire logic power_good_oe,
    output logic ext_clock_in,
    output logic pg_pin
);
    // 5 MHz source, holds its level while switched off
    initial begin
        ext_clock_in = 1'b0;
        forever begin
            #100;
            if (ext_on) begin
                ext_clock_in = ~ext_clock_in;
            end
        end
    end
    // Board pull-up: a released pin reads high
    assign pg_pin = power_good_oe ? power_good_out : 1'b1;
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import pgc_pkg::*;
    logic clk, rst_n, reg_we, reg_re, int_request, dev_standby, dev_active, double_delay;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] reg_uv_ok, reg_ov_ok, reg_ilim;
    logic ext_on, ext_clock_in, power_good_out, power_good_oe, irq_out_n, pll_enable;
    logic use_ext_clock, ext_clk_irq, delay_step_tick, pg_pin, rd_pend;
    logic [7:0] exp_q[$];
    logic [31:0] seed;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_irq = 0;

    pgc_ctrl #(.STEP_FULL(20), .STEP_FULL_DBL(40), .STEP_HALF(13), .STEP_HALF_DBL(26),
        .DEB_LONG(300)) u_pgc_ctrl (.*);
    pgc_far_model u_pgc_far_model (.*);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic look(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_re <= 1'b0;
    endtask

    task automatic blip();
        @(posedge clk) reg_uv_ok <= 4'he;
        look(6);
        @(posedge clk) reg_uv_ok <= 4'hf;
    endtask

    task automatic tick_per(input int e);
        int n;
        n = 0;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (delay_step_tick !== 1'b1 && n < 200);
        end
        check(n, e);
    endtask

    task automatic ext(input logic on, input logic use_exp, input int irq_exp);
        @(posedge clk) ext_on <= on;
        look(60);
        check(use_ext_clock, use_exp);
        check(n_irq, irq_exp);
    endtask

    // Read data lands one cycle after the read edge
    always @(posedge clk) begin
        rd_pend <= reg_re & rst_n;
        if (ext_clk_irq === 1'b1) begin
            n_irq <= n_irq + 1;
        end
    end
    always @(negedge clk) begin
        if (rd_pend === 1'b1 && exp_q.size() > 0) begin
            check(reg_rdata, exp_q.pop_front());
        end
    end

    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        {reg_we, reg_re, int_request, dev_standby, dev_active, double_delay, ext_on} = '0;
        {reg_addr, reg_wdata, reg_ilim} = '0;
        reg_uv_ok = 4'hf;
        reg_ov_ok = 4'hf;
        seed = 32'h0000_004c;
        look(20);
        check(power_good_oe, 1'b1);
        check(irq_out_n, 1'b1);
        check(pll_enable, 1'b0);
        @(posedge clk) rst_n <= 1'b1;
        for (logic [7:0] a = 8'h28; a < 8'h31; a++) rd(a, 8'h00);
        repeat (4) begin
            seed = xs(seed);
            wr(ADDR_PG_CTRL, seed[7:0]);
            rd(ADDR_PG_CTRL, seed[7:0] & MASK_PG_CTRL);
            wr(ADDR_PG_SRC, seed[15:8] & 8'h55);
            rd(ADDR_PG_SRC, seed[15:8] & 8'h55);
        end
        wr(ADDR_PG_FAULT, 8'hff);
        rd(ADDR_PG_FAULT, 8'h00);
        wr(ADDR_CLK_CTRL, 8'h37);
        rd(ADDR_CLK_CTRL, 8'h17);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_PG_CTRL, {i[1], 7'h00});
            double_delay <= i[0];
            tick_per(i[1] ? (i[0] ? 26 : 13) : (i[0] ? 40 : 20));
        end
        // Regulator 0 watched, regulator 1 masked
        wr(ADDR_PG_CTRL, 8'h00);
        wr(ADDR_PG_SRC, 8'h01);
        look(250);
        check(pg_pin, 1'b1);
        check(power_good_oe, 1'b1);
        // Selector 3 adds the current limit to the voltage check
        wr(ADDR_PG_SRC, 8'h03);
        @(posedge clk) reg_ilim <= 4'h1;
        look(6);
        check(pg_pin, 1'b0);
        @(posedge clk) reg_ilim <= 4'h0;
        wr(ADDR_PG_SRC, 8'h01);
        @(posedge clk) reg_uv_ok <= 4'hc;
        look(6);
        check(pg_pin, 1'b0);
        rd(ADDR_PG_FAULT, 8'h01);
        rd(ADDR_PG_FAULT, 8'h01);
        @(posedge clk) reg_uv_ok <= 4'hf;
        look(150);
        check(pg_pin, 1'b0);
        look(70);
        check(pg_pin, 1'b1);
        rd(ADDR_PG_FAULT, 8'h01);
        rd(ADDR_PG_FAULT, 8'h00);
        wr(ADDR_PG_CTRL, 8'h10);
        blip();
        look(250);
        check(pg_pin, 1'b0);
        rd(ADDR_PG_FAULT, 8'h01);
        look(250);
        check(pg_pin, 1'b1);
        wr(ADDR_PG_CTRL, 8'h20);
        blip();
        look(250);
        check(pg_pin, 1'b0);
        look(70);
        check(pg_pin, 1'b1);
        wr(ADDR_PG_CTRL, 8'h00);
        @(posedge clk) reg_ov_ok <= 4'he;
        look(6);
        check(pg_pin, 1'b1);
        wr(ADDR_PG_CTRL, 8'h04);
        look(6);
        check(pg_pin, 1'b0);
        @(posedge clk) reg_ov_ok <= 4'hf;
        wr(ADDR_PG_CTRL, 8'h01);
        look(250);
        check(pg_pin, 1'b0);
        wr(ADDR_PG_CTRL, 8'h03);
        look(4);
        check(power_good_oe, 1'b1);
        check(pg_pin, 1'b0);
        @(posedge clk) reg_uv_ok <= 4'he;
        look(6);
        check(pg_pin, 1'b1);
        check(power_good_oe, 1'b0);
        wr(ADDR_PG_CTRL, 8'h40);
        look(3);
        check(irq_out_n, 1'b0);
        @(posedge clk) reg_uv_ok <= 4'hf;
        look(8);
        check(irq_out_n, 1'b1);
        wr(ADDR_PG_CTRL, 8'h00);
        @(posedge clk) reg_uv_ok <= 4'he;
        look(6);
        check(irq_out_n, 1'b1);
        @(posedge clk) int_request <= 1'b1;
        look(3);
        check(irq_out_n, 1'b0);
        @(posedge clk) int_request <= 1'b0;
        // External clock at 5 MHz, rate code 4
        wr(ADDR_CLK_CTRL, 8'h44);
        @(posedge clk) dev_standby <= 1'b1;
        look(4);
        check(pll_enable, 1'b1);
        ext(1'b1, 1'b1, 1);
        ext(1'b0, 1'b0, 2);
        wr(ADDR_CLK_CTRL, 8'h84);
        look(4);
        check(pll_enable, 1'b0);
        ext(1'b1, 1'b0, 3);
        @(posedge clk) dev_standby <= 1'b0;
        dev_active <= 1'b1;
        look(4);
        check(pll_enable, 1'b1);
        check(use_ext_clock, 1'b1);
        wr(ADDR_CLK_CTRL, 8'h04);
        look(4);
        check(pll_enable, 1'b0);
        ext(1'b0, 1'b0, 3);
        summarize();
    end
endmodule
